//--- logic/sdc_pkg.sv
// Package: command codes, mode fields, burst state and carrier types
package sdc_pkg;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int NBANK = 4;
    localparam int BYTES = 9;
    localparam int DATA_W = 72;
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int CL_LSB = 4;
    localparam int CL_MSB = 6;
    localparam int WB_BIT = 9;
    localparam int PRE_BIT = 10;
    localparam logic [11:0] MODE_RESET = 12'h0_020;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [9:0] PAGE_LEN = 10'h2_00;
    // Encodings of {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_MRS = 3'h0;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank_select_high;
        logic bank_select_low;
        logic [ROW_W-1:0] addr;
        logic [BYTES-1:0] dqm;
    } sdc_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } sdc_burst_type;
endpackage

//--- logic/sdc_bus_driver.sv
// Input bus driver: transparent or clocked latch with tristate output
`timescale 1ns/1ps
`default_nettype none
module sdc_bus_driver #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic driver_output_enable_n,
    input wire logic driver_latch_enable,
    input wire logic [W-1:0] a,
    output logic [W-1:0] y,
    output logic [W-1:0] y_oe
);
    import sdc_pkg::*;

    typedef struct packed {
        logic [W-1:0] held;
    } sdc_drv_type;

    sdc_drv_type st;
    sdc_drv_type next_st;

    always_comb begin
        next_st = st;
        // Captured every edge so a raised latch enable holds the last level
        next_st.held = a;
    end

    // Reset latches a deselect, never an all-low mode load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    // Low latch enable passes the input straight through
    assign y = driver_latch_enable ? st.held : a;
    assign y_oe = driver_output_enable_n ? '0 : '1;
endmodule
`default_nettype wire

//--- logic/sdc_core.sv
// Command decoder, bank tracker, burst engine and byte-masked storage
`timescale 1ns/1ps
`default_nettype none
module sdc_core #(
    parameter int MEM_COLS = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic driver_output_enable_n,
    input wire logic driver_latch_enable,
    input wire sdc_pkg::sdc_cmd_type cmd_in,
    input wire logic [sdc_pkg::DATA_W-1:0] dq_in,
    output logic [sdc_pkg::DATA_W-1:0] dq_out,
    output logic [sdc_pkg::BYTES-1:0] dq_oe,
    output logic [sdc_pkg::NBANK-1:0] bank_open,
    output logic [11:0] mode_reg,
    output logic [12:0] refresh_row
);
    import sdc_pkg::*;

    localparam int CW = $bits(sdc_cmd_type);
    localparam int AW = $clog2(MEM_COLS);

    typedef struct packed {
        logic [11:0] mode;
        logic [NBANK-1:0] open;
        logic [NBANK-1:0][ROW_W-1:0] row;
        sdc_burst_type burst;
        logic [1:0] bbank;
        logic [COL_W-1:0] col;
        logic [9:0] left;
        logic autopre;
        logic [2:0] rd_valid;
        logic [2:0][AW+1:0] rd_addr;
        logic [1:0][BYTES-1:0] dqm_pipe;
        logic [DATA_W-1:0] dq_out;
        logic [BYTES-1:0] dq_oe;
        logic [12:0] refcnt;
        logic [NBANK*MEM_COLS-1:0][DATA_W-1:0] mem;
    } sdc_state_type;

    sdc_state_type st;
    sdc_state_type next_st;
    sdc_cmd_type cmd;
    logic [CW-1:0] cmd_bits;
    logic [CW-1:0] cmd_oe;

    sdc_bus_driver #(
        .W(CW)
    ) u_drv (
        .clk(clk),
        .rst(rst),
        .driver_output_enable_n(driver_output_enable_n),
        .driver_latch_enable(driver_latch_enable),
        .a(cmd_in),
        .y(cmd_bits),
        .y_oe(cmd_oe)
    );

    // A floated driver reads as deselect
    assign cmd = (&cmd_oe) ? sdc_cmd_type'(cmd_bits) : '1;

    function automatic logic [9:0] burst_len(input logic [2:0] f);
        case (f)
            BL_1: burst_len = 10'h0_01;
            BL_2: burst_len = 10'h0_02;
            BL_4: burst_len = 10'h0_04;
            BL_8: burst_len = 10'h0_08;
            default: burst_len = PAGE_LEN;
        endcase
    endfunction

    // Next column, wrapping inside the burst block
    function automatic logic [COL_W-1:0] next_col(
        input logic [COL_W-1:0] c,
        input logic [9:0] len
    );
        logic [COL_W-1:0] m;
        m = len[COL_W-1:0] - 9'h0_01;
        if (len == PAGE_LEN) begin
            next_col = c + 9'h0_01;
        end else begin
            next_col = (c & ~m) | ((c + 9'h0_01) & m);
        end
    endfunction

    function automatic logic [AW+1:0] mem_index(
        input logic [1:0] b,
        input logic [COL_W-1:0] c
    );
        mem_index = {b, c[AW-1:0]};
    endfunction

    logic [9:0] len;
    logic [2:0] op;
    logic [1:0] cbank;
    logic [AW+1:0] idx;
    logic [9:0] wlen;
    logic [AW+1:0] cidx;

    always_comb begin
        next_st = st;
        len = burst_len(st.mode[BL_MSB:BL_LSB]);
        op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
        cbank = {cmd.bank_select_high, cmd.bank_select_low};
        idx = mem_index(st.bbank, st.col);
        cidx = mem_index(cbank, cmd.addr[COL_W-1:0]);
        // Write burst bit makes writes single beats
        wlen = (op == CMD_WR && st.mode[WB_BIT]) ? 10'h0_01 : len;
        next_st.dqm_pipe = {st.dqm_pipe[0], cmd.dqm};
        next_st.rd_valid = {st.rd_valid[1:0], 1'b0};
        next_st.rd_addr = {st.rd_addr[1:0], idx};

        // Running burst advances; a terminate drops this beat and a new read or write restarts it
        if (st.burst == ST_READ) begin
            next_st.rd_valid[0] = 1'b1;
        end
        if (st.burst == ST_WRITE) begin
            for (int i = 0; i < BYTES; i++) begin
                if (!cmd.dqm[i]) begin
                    next_st.mem[idx][i*8 +: 8] = dq_in[i*8 +: 8];
                end
            end
        end
        if (st.burst != ST_IDLE) begin
            next_st.col = next_col(st.col, len);
            next_st.left = st.left - 10'h0_01;
            if (st.left == 10'h0_01 && len != PAGE_LEN) begin
                next_st.burst = ST_IDLE;
                if (st.autopre) begin
                    next_st.open[st.bbank] = 1'b0;
                end
            end
            if (len == PAGE_LEN && st.left == 10'h0_01) begin
                next_st.left = PAGE_LEN;
            end
        end

        if (!cmd.cs_n) begin
            case (op)
                CMD_MRS: begin
                    next_st.mode = cmd.addr[11:0];
                end
                CMD_ACT: begin
                    next_st.open[cbank] = 1'b1;
                    next_st.row[cbank] = cmd.addr;
                end
                CMD_RD, CMD_WR: begin
                    next_st.burst = (op == CMD_RD) ? ST_READ : ST_WRITE;
                    next_st.bbank = cbank;
                    // First beat is taken with the command itself
                    next_st.col = next_col(cmd.addr[COL_W-1:0], len);
                    next_st.left = wlen - 10'h0_01;
                    // Fresh decision each command, not for full page
                    next_st.autopre = cmd.addr[PRE_BIT] &&
                        (st.mode[BL_MSB:BL_LSB] != BL_PAGE);
                    if (op == CMD_RD) begin
                        next_st.rd_valid[0] = 1'b1;
                        next_st.rd_addr[0] = cidx;
                    end else begin
                        for (int i = 0; i < BYTES; i++) begin
                            if (!cmd.dqm[i]) begin
                                next_st.mem[cidx][i*8 +: 8] = dq_in[i*8 +: 8];
                            end
                        end
                    end
                    if (wlen == 10'h0_01) begin
                        next_st.burst = ST_IDLE;
                        if (next_st.autopre) begin
                            next_st.open[cbank] = 1'b0;
                        end
                    end
                end
                CMD_BST: begin
                    // The beat of the terminate cycle itself is dropped
                    next_st.burst = ST_IDLE;
                    next_st.rd_valid[0] = 1'b0;
                    next_st.mem = st.mem;
                end
                CMD_PRE: begin
                    if (cmd.addr[PRE_BIT]) begin
                        next_st.open = '0;
                    end else begin
                        next_st.open[cbank] = 1'b0;
                    end
                end
                CMD_REF: begin
                    next_st.refcnt = st.refcnt + 13'h0_001;
                end
                default: begin
                end
            endcase
        end

        // Latency 3 uses the deeper tap of the read pipe
        if (st.mode[CL_MSB:CL_LSB] == CL_3) begin
            for (int i = 0; i < BYTES; i++) begin
                next_st.dq_oe[i] = st.rd_valid[2] & ~st.dqm_pipe[1][i];
            end
            next_st.dq_out = st.mem[st.rd_addr[2]];
        end else begin
            for (int i = 0; i < BYTES; i++) begin
                next_st.dq_oe[i] = st.rd_valid[1] & ~st.dqm_pipe[1][i];
            end
            next_st.dq_out = st.mem[st.rd_addr[1]];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.mode <= MODE_RESET;
            st.burst <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign dq_out = st.dq_out;
    assign dq_oe = st.dq_oe;
    assign bank_open = st.open;
    assign mode_reg = st.mode;
    assign refresh_row = st.refcnt;
endmodule
`default_nettype wire

//--- tb/sdc_sva.sv
// Checker for the command core ports
`timescale 1ns/1ps
`default_nettype none
module sdc_sva
    import sdc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic driver_output_enable_n,
    input wire logic driver_latch_enable,
    input wire sdc_pkg::sdc_cmd_type cmd_in,
    input wire logic [sdc_pkg::NBANK-1:0] bank_open,
    input wire logic [11:0] mode_reg,
    input wire logic [sdc_pkg::BYTES-1:0] dq_oe,
    input wire logic [12:0] refresh_row
);
    sdc_cmd_type held;
    sdc_cmd_type eff;
    logic sel;
    logic [2:0] op;
    logic [1:0] bk;
    // Latched driver mode presents the command of the previous edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= '1;
        end else begin
            held <= cmd_in;
        end
    end
    assign eff = driver_latch_enable ? held : cmd_in;
    assign sel = !driver_output_enable_n && !eff.cs_n;
    assign op = {eff.ras_n, eff.cas_n, eff.we_n};
    assign bk = {eff.bank_select_high, eff.bank_select_low};
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_mode_load: assert property (
        sel && op == CMD_MRS |=> mode_reg == $past(eff.addr))
        else $error("mode register missed its load");
    a_deselect_quiet: assert property (
        !sel |=> $stable(mode_reg) && (bank_open & ~$past(bank_open)) == 0)
        else $error("deselected command took effect");
    a_nop_quiet: assert property (
        sel && op == CMD_NOP |=> $stable(mode_reg)
            && (bank_open & ~$past(bank_open)) == 0)
        else $error("idle command took effect");
    a_act_opens: assert property (
        sel && op == CMD_ACT |=> bank_open[$past(bk)])
        else $error("activated bank not open");
    a_pre_all: assert property (
        sel && op == CMD_PRE && eff.addr[PRE_BIT] |=> bank_open == 0)
        else $error("banks still open after full precharge");
    a_pre_one: assert property (
        sel && op == CMD_PRE && !eff.addr[PRE_BIT]
            |=> !bank_open[$past(bk)])
        else $error("bank still open after precharge");
    a_refresh_step: assert property (
        sel && op == CMD_REF |=> refresh_row == $past(refresh_row) + 13'h1)
        else $error("refresh counter did not advance");
    a_read_drive: assert property (
        sel && op == CMD_RD && eff.dqm != 9'h1ff |-> ##[2:4] dq_oe != 0)
        else $error("read data never driven");
endmodule
bind sdc_core sdc_sva u_sva (.clk(clk), .rst(rst),
    .driver_output_enable_n(driver_output_enable_n),
    .driver_latch_enable(driver_latch_enable), .cmd_in(cmd_in),
    .bank_open(bank_open), .mode_reg(mode_reg), .dq_oe(dq_oe),
    .refresh_row(refresh_row));
`default_nettype wire

//--- tb/sdc_ctrl_model.sv
// Memory controller model: issues commands and keeps its own timing
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model
    import sdc_pkg::*;
#(
    parameter int MODE_LOAD_DELAY = 2,
    parameter int PRECHARGE_PERIOD = 3,
    parameter int ROW_CYCLE_PERIOD = 2
) (
    input wire logic clk,
    output sdc_pkg::sdc_cmd_type cmd,
    output logic [sdc_pkg::DATA_W-1:0] dq,
    output logic oe_n,
    output logic le
);
    logic nxt_oe_n;
    logic nxt_le;
    initial begin
        cmd = '1;
        dq = '0;
        oe_n = 1'b0;
        le = 1'b0;
        nxt_oe_n = 1'b0;
        nxt_le = 1'b0;
    end
    // Driver pin levels applied together with the next command
    task automatic pins(input logic o, input logic l);
        nxt_oe_n = o;
        nxt_le = l;
    endtask
    task automatic hold(input int n);
        repeat (n) begin
            @(negedge clk);
            cmd = sdc_cmd_type'({1'b0, CMD_NOP, 23'h0});
            dq = ~dq;
        end
    endtask
    task automatic send(input logic [3:0] c, input logic [1:0] b,
        input logic [11:0] a, input logic [8:0] m,
        input logic dv = 1'b0, input logic [71:0] d = '0);
        @(negedge clk);
        cmd = sdc_cmd_type'({c, b, a, m});
        dq = dv ? d : ~dq;
        oe_n = nxt_oe_n;
        le = nxt_le;
        if (c == {1'b0, CMD_MRS}) hold(MODE_LOAD_DELAY);
        if (c == {1'b0, CMD_PRE}) hold(PRECHARGE_PERIOD);
        if (c == {1'b0, CMD_REF}) hold(ROW_CYCLE_PERIOD);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_sdram_command_protocol.sv
// Self-checking bench for the command core
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_protocol;
    import sdc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic oe_n;
    logic le;
    sdc_cmd_type cmd;
    logic [DATA_W-1:0] dq_in, dq_out, a0, a1, b0, b1, msk;
    logic [BYTES-1:0] dq_oe;
    logic [NBANK-1:0] bank_open;
    logic [11:0] mode_reg;
    logic [12:0] refresh_row, ref0;
    logic [80:0] note;
    logic [80:0] expq[$];
    int num_errors = 0;
    int comparisons = 0;
    int seed = 4;
    always #12.5 clk = ~clk;
    sdc_ctrl_model u_ctrl (.clk(clk), .cmd(cmd), .dq(dq_in), .oe_n(oe_n),
        .le(le));
    sdc_core #(.MEM_COLS(16)) dut (.clk(clk), .rst(rst),
        .driver_output_enable_n(oe_n), .driver_latch_enable(le),
        .cmd_in(cmd), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .bank_open(bank_open), .mode_reg(mode_reg),
        .refresh_row(refresh_row));
    function automatic logic [71:0] rnd();
        logic [95:0] r;
        r = {$random(seed), $random(seed), $random(seed)};
        return r[71:0];
    endfunction
    task automatic check_val(input logic [80:0] got, input logic [80:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_beat(input logic [80:0] exp);
        for (int i = 0; i < BYTES; i++) msk[i*8 +: 8] = {8{exp[DATA_W+i]}};
        check_val({dq_oe, dq_out & msk}, exp);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read beats are taken off the queue as they appear
    always @(negedge clk) begin
        if (!rst && dq_oe !== 9'h000) begin
            note = expq.size() > 0 ? expq.pop_front() : 81'h0;
            check_beat(note);
        end
    end
    initial begin
        #100_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check_val(81'(mode_reg), 81'(MODE_RESET));
        check_val(81'(bank_open), 81'h0);
        u_ctrl.send({1'b0, CMD_MRS}, 2'h0, 12'h021, 9'h000);
        check_val(81'(mode_reg), 81'h21);
        for (int i = 0; i < 3; i++) begin
            u_ctrl.pins(i == 1, 1'b0);
            u_ctrl.send({i == 0, i == 2 ? CMD_NOP : CMD_MRS}, 2'h0,
                12'(rnd()), 9'h000);
        end
        check_val(81'(mode_reg), 81'h21);
        u_ctrl.send({1'b0, CMD_ACT}, 2'h2, 12'(rnd()), 9'h000);
        u_ctrl.send({1'b0, CMD_ACT}, 2'h1, 12'(rnd()), 9'h000);
        u_ctrl.hold(1);
        check_val(81'(bank_open), 81'h6);
        a0 = rnd();
        a1 = rnd();
        b0 = rnd();
        b1 = rnd();
        for (int k = 0; k < 2; k++) begin
            u_ctrl.send({1'b0, CMD_WR}, 2'h2, 12'h000, 9'h000, 1'b1,
                k ? b0 : a0);
            u_ctrl.send({1'b0, CMD_NOP}, 2'h0, 12'h000, k ? 9'h001 : 9'h000,
                1'b1, k ? b1 : a1);
        end
        expq.push_back({9'h1fe, b0 & ~72'hff});
        expq.push_back({9'h1ff, b1[71:8], a1[7:0]});
        u_ctrl.send({1'b0, CMD_RD}, 2'h2, 12'h400, 9'h001);
        u_ctrl.hold(8);
        for (int i = 0; i < 12 && bank_open[2] !== 1'b0; i++) @(negedge clk);
        check_val(81'(bank_open), 81'h2);
        u_ctrl.send({1'b0, CMD_PRE}, 2'h1, 12'h000, 9'h000);
        check_val(81'(bank_open), 81'h0);
        u_ctrl.send({1'b0, CMD_ACT}, 2'h0, 12'(rnd()), 9'h000);
        u_ctrl.hold(1);
        u_ctrl.pins(1'b0, 1'b1);
        u_ctrl.send({1'b0, CMD_ACT}, 2'h3, 12'(rnd()), 9'h000);
        u_ctrl.hold(1);
        check_val(81'(bank_open), 81'h1);
        u_ctrl.hold(1);
        check_val(81'(bank_open), 81'h9);
        u_ctrl.pins(1'b0, 1'b0);
        u_ctrl.send({1'b0, CMD_PRE}, 2'h1, 12'h400, 9'h000);
        check_val(81'(bank_open), 81'h0);
        ref0 = refresh_row;
        repeat (3) u_ctrl.send({1'b0, CMD_REF}, 2'(rnd()), 12'(rnd()), 9'h000);
        check_val(81'(refresh_row), 81'(ref0 + 13'h3));
        // Latency 3, burst of 4, single-beat writes, cut after two beats
        u_ctrl.send({1'b0, CMD_MRS}, 2'h0, 12'h232, 9'h000);
        check_val(81'(mode_reg), 81'h232);
        u_ctrl.send({1'b0, CMD_ACT}, 2'h1, 12'(rnd()), 9'h000);
        a0 = rnd();
        u_ctrl.send({1'b0, CMD_WR}, 2'h1, 12'h004, 9'h000, 1'b1, a0);
        u_ctrl.send({1'b0, CMD_NOP}, 2'h0, 12'h000, 9'h000);
        expq.push_back({9'h1ff, a0});
        expq.push_back({9'h1ff, 72'h0});
        u_ctrl.send({1'b0, CMD_RD}, 2'h1, 12'h004, 9'h000);
        u_ctrl.send({1'b0, CMD_NOP}, 2'h0, 12'h000, 9'h000);
        u_ctrl.send({1'b0, CMD_BST}, 2'h0, 12'h000, 9'h000);
        u_ctrl.hold(8);
        check_val(81'(expq.size()), 81'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
